// ===== hw/twp_pkg.sv
// Shared constants and types for the timer/watchdog divider block
package twp_pkg;
	localparam int DIV_WIDTH = 8;
	localparam int CFG_WIDTH = 12;
	localparam logic [11:0] CFG_ADDR = 12'hFFF;
	localparam int CFG_CP_HI = 11;
	localparam int CFG_CP_LO = 3;
	localparam int CFG_WDTEN_BIT = 2;
	localparam int CFG_OSC_HI = 1;
	localparam int CFG_OSC_LO = 0;
	localparam int OPT_OWNER_BIT = 3;
	localparam int OPT_RATIO_HI = 2;
	localparam int OPT_RATIO_LO = 0;
	localparam logic [7:0] OPT_RESET = 8'h3F;
	localparam logic [7:0] DIV_RESET = 8'h00;
	// Register port offsets
	localparam logic [3:0] REG_OPTION = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_CONFIG = 4'h2;
	localparam logic [3:0] REG_WDT_LIMIT = 4'h3;
	// Startup hold time
	localparam longint CLK_HZ = 20000000;
	localparam longint HOLD_US = 18000;
	localparam int HOLD_CYCLES = int'((HOLD_US * CLK_HZ) / 1000000);
	localparam logic [15:0] WDT_LIMIT_RESET = 16'hFFFF;

	typedef enum logic [1:0] {
		TWP_OSC_LP,
		TWP_OSC_XT,
		TWP_OSC_HS,
		TWP_OSC_RC
	} twp_osc_t;

	typedef enum {
		TWP_HOLD,
		TWP_RUN,
		TWP_SLEEP
	} twp_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} twp_bus_req_t;

	typedef struct packed {
		logic timer_write;
		logic wdt_clear;
		logic option_write;
		logic sleep;
		logic [7:0] option_value;
	} twp_cpu_cmd_t;
endpackage

// ===== hw/twp_sync.sv
// Two-stage synchroniser for a level from another clock domain
`timescale 1ns/1ps
module twp_sync (
	input wire logic clock,
	input wire logic nrst,
	input wire logic din,
	output logic dout
);
	logic stage1;
	always_ff @(posedge clock) begin
		if (!nrst) begin
			stage1 <= 1'b0;
			dout <= 1'b0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule // twp_sync

// ===== hw/twp_divider.sv
// Shared 8-bit synchronous divider with ratio tap selection
`timescale 1ns/1ps
module twp_divider #(
	parameter int WIDTH = twp_pkg::DIV_WIDTH
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clear,
	input wire logic tick,
	input wire logic [2:0] ratio,
	input wire logic to_timer,
	output logic div_out
);
	import twp_pkg::*;
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic [3:0] tap;

	always_comb begin
		next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
		// Timer divides by 2^(n+1), watchdog by 2^n
		tap = to_timer ? {1'b0, ratio} + 4'h1 : {1'b0, ratio};
		if (tap == 4'h0) begin
			div_out = tick;
		end else begin
			// Carry out of the tap bit marks one full divided period
			div_out = tick && (next_count[tap[2:0] - 3'h1 +: 1] == 1'b0)
				&& (count[tap[2:0] - 3'h1 +: 1] == 1'b1) && (tap <= 4'h8)
				&& ((count & ((8'h01 << (tap - 4'h1)) - 8'h01)) ==
				((8'h01 << (tap - 4'h1)) - 8'h01));
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			count <= DIV_RESET;
		end else if (clear) begin
			count <= DIV_RESET;
		end else if (tick) begin
			count <= next_count;
		end
	end
endmodule // twp_divider

// ===== hw/twp_top.sv
// Timer0/watchdog shared divider, configuration word, startup hold and sleep
// How it works
// - One 8-bit divider, timer or watchdog only
// - Option bits 3:0 pick owner and ratio
// - Run-state timer register writes clear divider when timer-owned
// - Watchdog clear zeroes watchdog and owned divider
// - Divider count never readable nor writable
// - Any reset zeroes the divider
// - Owner may change in run state without reset
// - Only config enable bit stops watchdog
// - Watchdog runs from its own RC clock
// - Startup hold keeps chip reset 18 ms
// - Sleep exits on external reset or time-out
// - Full variant: nine protect bits 11..3
// - Reduced variant: one protect bit, 11..4 zero
// - Config bit 2 enables watchdog
// - Oscillator bits 1:0 select RC/HS/XT/LP
// - Smallest variant: no watchdog, timer-only divider
// - Owner bit clear timer, set watchdog
// - Timer ratios 1:2 to 1:256
`timescale 1ns/1ps
module twp_top #(
	parameter bit FULL_VARIANT = 1'b1,
	parameter bit HAS_WATCHDOG = 1'b1,
	parameter int HOLD_COUNT = twp_pkg::HOLD_CYCLES,
	parameter logic [11:0] CONFIG_WORD = 12'hFFF
) (
	input wire logic clock,
	input wire logic nrst,
	input wire twp_pkg::twp_bus_req_t bus_req,
	output logic [15:0] rdata,
	input wire twp_pkg::twp_cpu_cmd_t cpu_cmd,
	input wire logic timer_source_tick,
	input wire logic wdt_rc_clock,
	output logic timer_advance,
	output logic chip_reset_hold,
	output logic watchdog_reset,
	output logic sleeping,
	output twp_pkg::twp_osc_t oscillator_mode
);
	import twp_pkg::*;

	twp_state_t state;
	logic [7:0] option_reg;
	logic [11:0] cfg_word;
	logic [31:0] hold_count;
	logic [15:0] wdt_count;
	logic [15:0] wdt_limit;
	logic rc_sync;
	logic rc_prev;
	logic rc_tick;
	logic wdt_enabled;
	logic owner_wdt;
	logic div_clear;
	logic div_tick;
	logic div_out;
	logic wdt_step;
	logic timeout;
	logic timeout_seen;

	function automatic logic [11:0] shape_config(input logic [11:0] raw, input bit full);
		logic [11:0] word;
		word = raw;
		if (!full) begin
			word[CFG_CP_HI:CFG_CP_LO+1] = '0;
		end
		return word;
	endfunction

	assign cfg_word = shape_config(CONFIG_WORD, FULL_VARIANT);
	// Only the configuration bit gates the watchdog; no software path reaches it
	assign wdt_enabled = HAS_WATCHDOG && cfg_word[CFG_WDTEN_BIT];
	assign oscillator_mode = twp_osc_t'(cfg_word[CFG_OSC_HI:CFG_OSC_LO]);
	// Owner bit set gives the divider to the watchdog, except where none exists
	assign owner_wdt = HAS_WATCHDOG && option_reg[OPT_OWNER_BIT];

	// Watchdog RC clock is foreign; sample it and detect its rising edge
	twp_sync u_rc_sync (
		.clock(clock),
		.nrst(nrst),
		.din(wdt_rc_clock),
		.dout(rc_sync)
	);

	always_ff @(posedge clock) begin
		if (!nrst) begin
			rc_prev <= 1'b0;
		end else begin
			rc_prev <= rc_sync;
		end
	end
	assign rc_tick = rc_sync && !rc_prev;

	assign div_tick = owner_wdt ? (rc_tick && wdt_enabled) : timer_source_tick;
	assign div_clear = state == TWP_HOLD
		|| (!owner_wdt && cpu_cmd.timer_write && state == TWP_RUN)
		|| (owner_wdt && cpu_cmd.wdt_clear);

	twp_divider #(
		.WIDTH(DIV_WIDTH)
	) u_divider (
		.clock(clock),
		.nrst(nrst),
		.clear(div_clear),
		.tick(div_tick),
		.ratio(option_reg[OPT_RATIO_HI:OPT_RATIO_LO]),
		.to_timer(!owner_wdt),
		.div_out(div_out)
	);

	// Only the divided output advances the timer when the divider serves it
	assign timer_advance = !owner_wdt && div_out && state == TWP_RUN;
	assign wdt_step = wdt_enabled && (owner_wdt ? div_out : rc_tick);

	// Option register: written only in run state, no halt; divider is never reloaded here
	always_ff @(posedge clock) begin
		if (!nrst) begin
			option_reg <= OPT_RESET;
		end else if (cpu_cmd.option_write && state == TWP_RUN) begin
			option_reg <= cpu_cmd.option_value;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			wdt_limit <= WDT_LIMIT_RESET;
		end else if (bus_req.wr && bus_req.addr == REG_WDT_LIMIT) begin
			wdt_limit <= bus_req.wdata;
		end
	end

	// Watchdog counter; the CPU keeps the safe switch sequences
	always_ff @(posedge clock) begin
		if (!nrst || state == TWP_HOLD) begin
			wdt_count <= 16'h0000;
		end else if (cpu_cmd.wdt_clear) begin
			wdt_count <= 16'h0000;
		end else if (wdt_step) begin
			wdt_count <= wdt_count + 16'h0001;
		end
	end
	assign timeout = wdt_enabled && wdt_step && wdt_count == wdt_limit;

	// Startup hold counter: external reset starts it, time-out reset too
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state <= TWP_HOLD;
			hold_count <= 32'h00000000;
		end else begin
			case (state)
				TWP_HOLD: begin
					if (hold_count >= 32'(HOLD_COUNT - 1)) begin
						state <= TWP_RUN;
						hold_count <= 32'h00000000;
					end else begin
						hold_count <= hold_count + 32'h00000001;
					end
				end
				TWP_RUN: begin
					if (timeout) begin
						state <= TWP_HOLD;
					end else if (cpu_cmd.sleep) begin
						state <= TWP_SLEEP;
					end
				end
				TWP_SLEEP: begin
					// Only a watchdog time-out or nrst leaves sleep
					if (timeout) begin
						state <= TWP_HOLD;
					end
				end
				default: state <= TWP_HOLD;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			timeout_seen <= 1'b0;
		end else if (timeout) begin
			timeout_seen <= 1'b1;
		end else if (bus_req.rd && bus_req.addr == REG_STATUS) begin
			timeout_seen <= 1'b0;
		end
	end

	assign chip_reset_hold = state == TWP_HOLD;
	assign watchdog_reset = timeout;
	assign sleeping = state == TWP_SLEEP;

	// Read port: the divider count is deliberately absent
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rdata <= 16'h0000;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				REG_OPTION: rdata <= {8'h00, option_reg};
				REG_STATUS: rdata <= {12'h000, timeout_seen, sleeping, owner_wdt,
					wdt_enabled};
				REG_CONFIG: rdata <= {4'h0, cfg_word};
				REG_WDT_LIMIT: rdata <= wdt_limit;
				default: rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule // twp_top

// ===== verif/twp_top_sva.sv
// Port checker for the shared divider block
`timescale 1ns/1ps
module twp_top_sva #(
	parameter bit FULL_VARIANT = 1'b1,
	parameter bit HAS_WATCHDOG = 1'b1,
	parameter logic [11:0] CONFIG_WORD = 12'hFFF
) (
	input wire logic clock,
	input wire logic nrst,
	input wire twp_pkg::twp_bus_req_t bus_req,
	input wire logic [15:0] rdata,
	input wire logic timer_source_tick,
	input wire logic timer_advance,
	input wire logic chip_reset_hold,
	input wire logic watchdog_reset,
	input wire logic sleeping,
	input wire twp_pkg::twp_osc_t oscillator_mode
);
	import twp_pkg::*;
	localparam logic [15:0] CFG_EXP = FULL_VARIANT ? {4'h0, CONFIG_WORD} :
		{12'h000, CONFIG_WORD[3:0]};
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence s_cfg_rd;
		bus_req.rd && bus_req.addr == REG_CONFIG;
	endsequence
	a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rdata == 16'h0000)
		else $error("rdata not idle");
	a_cfg_read: assert property (s_cfg_rd |=> rdata == CFG_EXP)
		else $error("config word wrong");
	a_osc_fixed: assert property (oscillator_mode ==
		twp_osc_t'(CONFIG_WORD[CFG_OSC_HI:CFG_OSC_LO]))
		else $error("oscillator mode wrong");
	a_hold_start: assert property ($rose(nrst) |-> chip_reset_hold [*8])
		else $error("startup hold too short");
	a_adv_on_tick: assert property (timer_advance |-> timer_source_tick)
		else $error("advance without tick");
	a_wdt_cfg_off: assert property (!CONFIG_WORD[CFG_WDTEN_BIT] |-> !watchdog_reset)
		else $error("disabled watchdog fired");
	a_no_dog: assert property (!HAS_WATCHDOG |-> !watchdog_reset)
		else $error("absent watchdog fired");
	a_wake_cause: assert property ($fell(sleeping) |-> $past(watchdog_reset))
		else $error("woke without time-out");
endmodule // twp_top_sva
bind twp_top twp_top_sva #(.FULL_VARIANT(FULL_VARIANT), .HAS_WATCHDOG(HAS_WATCHDOG),
	.CONFIG_WORD(CONFIG_WORD)) i_twp_top_sva (.clock, .nrst, .bus_req, .rdata,
	.timer_source_tick, .timer_advance, .chip_reset_hold, .watchdog_reset, .sleeping,
	.oscillator_mode);

// ===== verif/twp_cpu_model.sv
// CPU core model issuing option, clear, timer-write and sleep instructions
`timescale 1ns/1ps
module twp_cpu_model (
	input wire logic clock,
	output twp_pkg::twp_cpu_cmd_t cpu_cmd
);
	import twp_pkg::*;
	initial cpu_cmd = '0;
	// Kind bits: timer write, watchdog clear, option write, sleep
	task op(input logic [3:0] k, input logic [7:0] v);
		@(posedge clock) cpu_cmd <= {k, v};
		@(posedge clock) cpu_cmd <= '0;
	endtask
	// Interim step keeps a short postscale from tripping mid-switch
	task to_dog(input logic [2:0] r);
		op(4'h4, 8'h00);
		op(4'h8, 8'h00);
		if (r < 3'd2) begin
			op(4'h2, 8'h0F);
			op(4'h4, 8'h00);
		end
		op(4'h2, {5'h01, r});
	endtask
	task to_tmr(input logic [2:0] r);
		op(4'h4, 8'h00);
		op(4'h2, {5'h00, r});
	endtask
endmodule // twp_cpu_model

// ===== verif/twp_top_test.sv
// Self-checking bench for the shared divider block
`timescale 1ns/1ps
module twp_top_test;
	import twp_pkg::*;
	logic clock = 0, nrst = 0, timer_source_tick = 0, wdt_rc_clock = 0;
	twp_bus_req_t bus_req = '0;
	twp_cpu_cmd_t cpu_cmd;
	logic [15:0] rdata;
	logic timer_advance, chip_reset_hold, watchdog_reset, sleeping;
	twp_osc_t oscillator_mode;
	logic [15:0] rdata_b;
	twp_osc_t osc_b;
	logic dog_b, dog_c;
	int miscompares = 0, n_compared = 0, n_adv = 0, n_dog = 0, cyc = 0, n_dog_x = 0;
	always #25 clock = ~clock;
	always #83 wdt_rc_clock = ~wdt_rc_clock;
	twp_top #(.HOLD_COUNT(8)) i_twp_top (.clock, .nrst, .bus_req, .rdata, .cpu_cmd,
		.timer_source_tick, .wdt_rc_clock, .timer_advance, .chip_reset_hold,
		.watchdog_reset, .sleeping, .oscillator_mode);
	// Reduced variant with the watchdog switched off in its configuration word
	twp_top #(.FULL_VARIANT(1'b0), .HOLD_COUNT(8), .CONFIG_WORD(12'hFF9)) i_twp_top_lite (
		.clock, .nrst, .bus_req, .rdata(rdata_b), .cpu_cmd, .timer_source_tick, .wdt_rc_clock,
		.timer_advance(), .chip_reset_hold(), .watchdog_reset(dog_b), .sleeping(),
		.oscillator_mode(osc_b));
	// Smallest variant: no watchdog at all although the enable bit is set
	twp_top #(.HAS_WATCHDOG(1'b0), .HOLD_COUNT(8)) i_twp_top_nodog (.clock, .nrst, .bus_req,
		.rdata(), .cpu_cmd, .timer_source_tick, .wdt_rc_clock, .timer_advance(),
		.chip_reset_hold(), .watchdog_reset(dog_c), .sleeping(), .oscillator_mode());
	twp_cpu_model cpu (.clock, .cpu_cmd);
	always @(posedge clock) begin
		cyc++;
		if (nrst && timer_advance === 1'b1) n_adv++;
		if (nrst && watchdog_reset === 1'b1) n_dog++;
		if (nrst && (dog_b === 1'b1 || dog_c === 1'b1)) n_dog_x++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	task end_sim;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e, input string n);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e, input string n);
		@(posedge clock) bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clock) bus_req <= '0;
		#1 chk(rdata, e, n);
	endtask
	task tick(input int n);
		repeat (n) begin
			@(posedge clock) timer_source_tick <= 1'b1;
			@(posedge clock) timer_source_tick <= 1'b0;
		end
	endtask
	task t_reset;
		int i;
		chk({15'h0, chip_reset_hold}, 16'h1, "hold");
		for (i = 0; i < 20 && chip_reset_hold !== 1'b0; i++) @(posedge clock);
		#1 chk({15'h0, chip_reset_hold}, 16'h0, "hold end");
		rd(REG_OPTION, 16'h003F, "option");
		rd(REG_CONFIG, 16'h0FFF, "config");
		chk(rdata_b, 16'h0009, "lite config");
		rd(4'hF, 16'h0000, "unmapped");
		chk({14'h0, oscillator_mode}, 16'h3, "osc");
		chk({14'h0, osc_b}, 16'h1, "lite osc");
		$display("reset test done");
	endtask
	task t_ratio;
		int n;
		for (n = 0; n < 8; n++) begin
			cpu.to_tmr(3'(n));
			cpu.op(4'h8, 8'h00);
			n_adv = 0;
			tick(4 << n);
			#1 chk(16'(n_adv), 16'h2, "advances");
		end
		cpu.to_tmr(3'd0);
		cpu.op(4'h8, 8'h00);
		tick(1);
		cpu.op(4'h8, 8'h00);
		n_adv = 0;
		tick(1);
		#1 chk(16'(n_adv), 16'h0, "cleared");
		tick(1);
		#1 chk(16'(n_adv), 16'h1, "after clear");
		chk(16'(n_dog), 16'h0, "no reset");
		$display("ratio test done");
	endtask
	task t_dog;
		int i;
		cpu.to_dog(3'd0);
		rd(REG_OPTION, 16'h0008, "dog option");
		@(posedge clock) bus_req <= '{REG_WDT_LIMIT, 16'h0004, 1'b1, 1'b0};
		@(posedge clock) bus_req <= '0;
		repeat (100) cpu.op(4'h4, 8'h00);
		chk(16'(n_dog), 16'h0, "kept alive");
		cpu.op(4'h1, 8'h00);
		#1 chk({15'h0, sleeping}, 16'h1, "asleep");
		for (i = 0; i < 400 && n_dog == 0; i++) @(posedge clock);
		chk(16'(n_dog), 16'h1, "time-out");
		repeat (2) @(posedge clock);
		#1 chk({15'h0, sleeping}, 16'h0, "woken");
		rd(REG_STATUS, 16'h000B, "status");
		rd(REG_STATUS, 16'h0003, "status cleared");
		chk(16'(n_dog_x), 16'h0000, "absent dogs");
		$display("watchdog test done");
	endtask
	initial begin
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		#1 t_reset();
		t_ratio();
		t_dog();
		end_sim();
	end
endmodule // twp_top_test
